/* File: hw/pvs_consts.svh */
// Constants for the polyphase video scaler: widths, reset values and counts.
// Included by the package and by every design file of the scaler except the FIFO.
`ifndef PVS_CONSTS_SVH
`define PVS_CONSTS_SVH
`define PVS_PIX_W 24
`define PVS_DIM_W 16
`define PVS_PITCH_W 24
`define PVS_FRAC_W 12
`define PVS_POS_W 28
`define PVS_PHASE_W 4
`define PVS_PHASES 16
`define PVS_FIFO_DEPTH 16
`define PVS_LINE_W 2048
`define PVS_RST_CYCLES 4'h1
`define PVS_RST_PITCH 24'h001000
`define PVS_RST_DIM 16'h0010
`endif

/* File: hw/pvs_ctrl.sv */
// Controlling end of the scaler link: holding video source, sink capture
// and parameter loader that pulses the scaler reset while the source idles.
// Assumes the user side sits on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "pvs_consts.svh"
module pvs_ctrl
  import pvs_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  pvs_if.ctl lnk,
  input wire logic [`PVS_PIX_W-1:0] src_pix,
  input wire logic src_fs,
  input wire logic src_ls,
  input wire logic src_val,
  output logic src_rdy,
  output logic [`PVS_PIX_W-1:0] snk_pix,
  output logic snk_fs,
  output logic snk_ls,
  output logic snk_val,
  input wire logic snk_rdy,
  input wire logic [`PVS_PITCH_W-1:0] par_pitch_x,
  input wire logic [`PVS_PITCH_W-1:0] par_pitch_y,
  input wire logic [`PVS_DIM_W-1:0] par_in_ppl,
  input wire logic [`PVS_DIM_W-1:0] par_in_lpf,
  input wire logic [`PVS_DIM_W-1:0] par_out_ppl,
  input wire logic [`PVS_DIM_W-1:0] par_out_lpf,
  input wire logic par_load,
  output logic par_busy
);
  localparam int SW = 2 * `PVS_PITCH_W + 4 * `PVS_DIM_W;
  logic sv_r;
  pvs_word_t sd_r;
  logic ordy_r;
  logic [SW-1:0] shadow_r;
  logic [SW-1:0] live_r;
  logic [3:0] rst_cnt_r;
  logic rst_r;

  // A new pixel is taken only when the held one is gone or leaving.
  assign src_rdy = !sv_r || lnk.in_rdy;
  wire src_take = src_val && src_rdy;
  wire idle = !sv_r && !src_val;
  wire apply = par_busy && idle;

  // Source register: pixel and markers stand until the scaler takes them.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sv_r <= 1'b0;
      sd_r <= '0;
    end else if (src_take) begin
      sv_r <= 1'b1;
      sd_r <= {src_fs, src_ls, src_pix};
    end else if (lnk.in_rdy) begin
      sv_r <= 1'b0;
    end
  end

  // Sink capture: only accepted pixels reach the user, as one-cycle pulses.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ordy_r <= 1'b0;
      snk_val <= 1'b0;
      snk_pix <= '0;
      snk_fs <= 1'b0;
      snk_ls <= 1'b0;
    end else begin
      ordy_r <= snk_rdy;
      snk_val <= lnk.out_val && ordy_r;
      if (lnk.out_val && ordy_r) begin
        snk_pix <= lnk.out_pix;
        snk_fs <= lnk.out_fs;
        snk_ls <= lnk.out_ls;
      end
    end
  end

  // Parameter loader: a load request wins over the clear of the same cycle.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      par_busy <= 1'b0;
      shadow_r <= '0;
      live_r <= {`PVS_RST_PITCH, `PVS_RST_PITCH, `PVS_RST_DIM, `PVS_RST_DIM,
        `PVS_RST_DIM, `PVS_RST_DIM};
      rst_cnt_r <= 4'h0;
      rst_r <= 1'b0;
    end else begin
      par_busy <= par_load || (par_busy && !apply);
      if (par_load) begin
        shadow_r <= {par_pitch_x, par_pitch_y, par_in_ppl, par_in_lpf, par_out_ppl, par_out_lpf};
      end
      if (apply) begin
        live_r <= shadow_r;
        rst_cnt_r <= `PVS_RST_CYCLES;
      end else if (rst_cnt_r != 4'h0) begin
        rst_cnt_r <= rst_cnt_r - 4'h1;
      end
      rst_r <= apply || (rst_cnt_r > 4'h1);
    end
  end

  assign lnk.in_val = sv_r;
  assign lnk.in_pix = sd_r.pix;
  assign lnk.in_fs = sd_r.fs;
  assign lnk.in_ls = sd_r.ls;
  assign lnk.out_rdy = ordy_r;
  assign lnk.scale_rst = rst_r;
  assign {lnk.pitch_x, lnk.pitch_y, lnk.in_ppl, lnk.in_lpf, lnk.out_ppl, lnk.out_lpf} = live_r;
endmodule // pvs_ctrl
`default_nettype wire

/* File: hw/pvs_fifo.sv */
// Synchronous FIFO in flip-flops with valid/ready on both sides.
// DEPTH must be a power of two; ready on the fill side is registered.
`timescale 1ns/1ps
`default_nettype none
module pvs_fifo #(
  parameter int W = 26,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] in_data,
  input wire logic in_val,
  output logic in_rdy,
  output logic [W-1:0] out_data,
  output logic out_val,
  input wire logic out_rdy
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  wire wr = in_val && in_rdy;
  wire rd = out_val && out_rdy;
  assign out_val = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign cnt_nxt = cnt_r + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
  // Ready is registered from the next fill level, so it never depends on valid.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      in_rdy <= 1'b0;
    end else begin
      wp_r <= wp_r + AW'(wr);
      rp_r <= rp_r + AW'(rd);
      cnt_r <= cnt_nxt;
      in_rdy <= (cnt_nxt < (AW+1)'(DEPTH));
    end
  end
  // Storage carries no reset; only written words are ever read.
  always_ff @(posedge clk) begin
    if (wr) begin
      mem_r[wp_r] <= in_data;
    end
  end
endmodule // pvs_fifo
`default_nettype wire

/* File: hw/pvs_if.sv */
// Link between the scaler and its controlling source/sink logic.
// Both ends run on the same clock; the testbench joins them.
`timescale 1ns/1ps
`default_nettype none
`include "pvs_consts.svh"
interface pvs_if;
  import pvs_pkg::*;
  logic [`PVS_PIX_W-1:0] in_pix;
  logic in_fs;
  logic in_ls;
  logic in_val;
  logic in_rdy;
  logic [`PVS_PIX_W-1:0] out_pix;
  logic out_fs;
  logic out_ls;
  logic out_val;
  logic out_rdy;
  logic [`PVS_PITCH_W-1:0] pitch_x;
  logic [`PVS_PITCH_W-1:0] pitch_y;
  logic [`PVS_DIM_W-1:0] in_ppl;
  logic [`PVS_DIM_W-1:0] in_lpf;
  logic [`PVS_DIM_W-1:0] out_ppl;
  logic [`PVS_DIM_W-1:0] out_lpf;
  logic scale_rst;
  modport dev (input in_pix, in_fs, in_ls, in_val, output in_rdy,
    output out_pix, out_fs, out_ls, out_val, input out_rdy,
    input pitch_x, pitch_y, in_ppl, in_lpf, out_ppl, out_lpf, scale_rst);
  modport ctl (output in_pix, in_fs, in_ls, in_val, input in_rdy,
    input out_pix, out_fs, out_ls, out_val, output out_rdy,
    output pitch_x, pitch_y, in_ppl, in_lpf, out_ppl, out_lpf, scale_rst);
endinterface // pvs_if
`default_nettype wire

/* File: hw/pvs_pkg.sv */
// Types and the shared interpolation function of the video scaler.
// Assumes pvs_consts.svh is on the include path.
`include "pvs_consts.svh"
package pvs_pkg;
  typedef logic [`PVS_PIX_W-1:0] pvs_pix_t;
  typedef logic [8:0] pvs_coef_t;
  typedef pvs_coef_t pvs_coef_tab_t [`PVS_PHASES];
  // A pixel with its frame-start and line-start markers.
  typedef struct packed {
    logic fs;
    logic ls;
    pvs_pix_t pix;
  } pvs_word_t;
  typedef enum logic [2:0] {
    PVS_WAIT = 3'b001,
    PVS_RUN = 3'b010,
    PVS_REPLAY = 3'b100
  } pvs_state_t;
  // Weight of the second tap per phase, out of 256; the first tap gets the rest.
  localparam pvs_coef_tab_t PVS_BILINEAR = '{9'h000, 9'h010, 9'h020, 9'h030, 9'h040,
    9'h050, 9'h060, 9'h070, 9'h080, 9'h090, 9'h0A0, 9'h0B0, 9'h0C0, 9'h0D0, 9'h0E0, 9'h0F0};
  // Two-tap blend of each 8-bit colour channel.
  function automatic pvs_pix_t pvs_lerp(input pvs_pix_t a, input pvs_pix_t b, input pvs_coef_t w);
    logic [16:0] acc;
    pvs_pix_t r;
    acc = 17'h00000;
    r = '0;
    for (int c = 0; c < 3; c++) begin
      acc = {9'h000, a[c*8 +: 8]} * (17'h00100 - {8'h00, w}) + {9'h000, b[c*8 +: 8]} * {8'h00, w};
      r[c*8 +: 8] = acc[15:8];
    end
    return r;
  endfunction
endpackage

/* File: hw/pvs_scaler.sv */
// Scaler end: input FIFO, horizontal two-tap stage, two linestores and a
// vertical two-tap stage, then a registered output. One clock, async reset.
// Assumes the controlling end holds the scale inputs steady and pulses
// scale_rst around any change.
// Functional notes
// - Transfer only when valid and ready high.
// - Ignore input lines while input valid low.
// - Frame's first pixel carries both markers.
// - Later lines' first pixel carries line marker.
// - No scaling before first frame-start accepted.
// - Downscaling keeps input ready mostly high.
// - Upscaling drops input ready to throttle source.
// - Source holds pixel while ready low.
// - Each output line starts with line marker.
// - Sink discards output while valid low.
// - Scale inputs used live every clock edge.
// - Controller keeps scale inputs steady during scaling.
// - Controller pulses reset on parameter change.
// - After reset, resume at next frame start.
// - Parameter change preferably during vertical blanking.
// - Two-tap horizontal then two-tap vertical filter.
// - Bilinear coefficients by default, replaceable.
// - Pitch is unsigned with twelve fraction bits.
// - Horizontal stage feeds vertical stage in series.
`timescale 1ns/1ps
`default_nettype none
`include "pvs_consts.svh"
module pvs_scaler
  import pvs_pkg::*;
#(
  parameter int LINE_W = `PVS_LINE_W,
  parameter int DEPTH = `PVS_FIFO_DEPTH,
  parameter pvs_coef_tab_t COEF_X = PVS_BILINEAR,
  parameter pvs_coef_tab_t COEF_Y = PVS_BILINEAR
) (
  input wire logic clk,
  input wire logic sys_rst,
  pvs_if.dev lnk
);
  localparam int LW = $clog2(LINE_W);
  localparam int DW = `PVS_DIM_W;
  localparam int PW = `PVS_POS_W;
  localparam int FW = `PVS_FRAC_W;
  // A new scale setting restarts everything from the next frame.
  wire core_rst = sys_rst || lnk.scale_rst;

  pvs_state_t st_r;
  logic [DW-1:0] hx_r;
  logic [DW-1:0] hout_r;
  logic [PW-1:0] hpos_r;
  pvs_pix_t p_prev_r;
  pvs_pix_t p_cur_r;
  logic [DW-1:0] vy_r;
  logic [DW-1:0] vout_r;
  logic [DW-1:0] rx_r;
  logic [PW-1:0] vpos_r;
  logic bank_r;
  pvs_pix_t lb_r [2][LINE_W];
  logic ov_r;
  pvs_word_t od_r;
  pvs_word_t f_w;
  logic f_val;
  logic f_take;

  // Input FIFO; its registered ready is the link's input ready.
  pvs_fifo #(.W($bits(pvs_word_t)), .DEPTH(DEPTH)) u_in_fifo (
    .clk(clk),
    .rst(core_rst),
    .in_data({lnk.in_fs, lnk.in_ls, lnk.in_pix}),
    .in_val(lnk.in_val),
    .in_rdy(lnk.in_rdy),
    .out_data(f_w),
    .out_val(f_val),
    .out_rdy(f_take)
  );

  // Integer parts of the 16.12 positions and the filter phases.
  wire [DW-1:0] hint = hpos_r[FW +: DW];
  wire [DW-1:0] vint = vpos_r[FW +: DW];
  wire [3:0] hph = hpos_r[FW-1 -: 4];
  wire [3:0] vph = vpos_r[FW-1 -: 4];
  wire h_pair = ({1'b0, hx_r} == {1'b0, hint} + 17'h00001);
  wire v_pair = ({1'b0, vy_r} == {1'b0, vint} + 17'h00001);

  // Horizontal decisions: an output is due once its right-hand tap has
  // arrived, or the line has run out and the last pixel is repeated.
  wire in_run = (st_r == PVS_RUN);
  wire in_rep = (st_r == PVS_REPLAY);
  wire line_brk = f_val && f_w.ls;
  wire h_last = (hx_r == lnk.in_ppl - 16'h0001) || line_brk;
  wire h_more = (hout_r < lnk.out_ppl);
  wire h_due = in_run && h_more && (({1'b0, hx_r} >= {1'b0, hint} + 17'h00001) || h_last);
  wire h_end = (hout_r == lnk.out_ppl - 16'h0001);

  // Vertical decisions: the last input line is repeated for any output
  // lines that still remain.
  wire v_last = (vy_r == lnk.in_lpf - 16'h0001);
  wire v_due = (vout_r < lnk.out_lpf) && (({1'b0, vy_r} >= {1'b0, vint} + 17'h00001) || v_last);
  wire out_free = !ov_r || lnk.out_rdy;
  wire h_go = h_due && (!v_due || out_free);
  wire r_go = in_rep && v_due && out_free;
  wire r_adv = in_rep && !v_due;
  wire r_end = (rx_r == lnk.out_ppl - 16'h0001);

  // Downscaling takes the next pixel in the same cycle as an output when the
  // next output still needs it, so the source keeps flowing. Upscaling stalls
  // the FIFO drain, so the FIFO fills and ready drops.
  wire [PW-1:0] hpos_nxt = hpos_r + {4'h0, lnk.pitch_x};
  wire [DW-1:0] hint_nxt = hpos_nxt[FW +: DW];
  wire h_ahead = h_go && !h_end && !h_last && !f_w.fs && (hint_nxt >= hx_r);
  assign f_take = f_val && ((st_r == PVS_WAIT) || (in_run && (!h_due || h_ahead)));

  // Filter datapath: horizontal result feeds the vertical taps directly.
  wire pvs_pix_t hpix = h_pair ? pvs_lerp(p_prev_r, p_cur_r, COEF_X[hph]) : p_cur_r;
  wire [DW-1:0] x_sel = in_rep ? rx_r : hout_r;
  wire pvs_pix_t v_old = lb_r[!bank_r][x_sel[LW-1:0]];
  wire pvs_pix_t v_new = in_rep ? lb_r[bank_r][x_sel[LW-1:0]] : hpix;
  wire pvs_pix_t vpix = v_pair ? pvs_lerp(v_old, v_new, COEF_Y[vph]) : v_new;
  wire o_load = (h_go && v_due) || r_go;

  // Sequencer: wait for a frame start, stream lines, replay stored lines.
  always_ff @(posedge clk or posedge core_rst) begin
    if (core_rst) begin
      st_r <= PVS_WAIT;
    end else if (f_take && f_w.fs && !in_rep) begin
      st_r <= PVS_RUN;
    end else if (h_go && h_end) begin
      st_r <= PVS_REPLAY;
    end else if (r_adv) begin
      st_r <= v_last ? PVS_WAIT : PVS_RUN;
    end
  end

  // Horizontal stage: pixel pair, input index, output count and position.
  always_ff @(posedge clk or posedge core_rst) begin
    if (core_rst) begin
      hx_r <= '0;
      hout_r <= '0;
      hpos_r <= '0;
      p_prev_r <= '0;
      p_cur_r <= '0;
    end else if (f_take && (f_w.fs || (in_run && f_w.ls))) begin
      hx_r <= '0;
      hout_r <= '0;
      hpos_r <= '0;
      p_cur_r <= f_w.pix;
    end else begin
      // A take and an output may share a cycle; the output uses the old pair.
      if (f_take && in_run && h_more) begin
        hx_r <= hx_r + 16'h0001;
        p_prev_r <= p_cur_r;
        p_cur_r <= f_w.pix;
      end
      if (h_go) begin
        hout_r <= hout_r + 16'h0001;
        hpos_r <= hpos_nxt;
      end
    end
  end

  // Vertical stage: line index, output line count, replay column, position.
  always_ff @(posedge clk or posedge core_rst) begin
    if (core_rst) begin
      vy_r <= '0;
      vout_r <= '0;
      vpos_r <= '0;
      rx_r <= '0;
      bank_r <= 1'b0;
    end else if (f_take && f_w.fs && !in_rep) begin
      vy_r <= '0;
      vout_r <= '0;
      vpos_r <= '0;
      rx_r <= '0;
      bank_r <= 1'b0;
    end else if ((h_go && h_end && v_due) || (r_go && r_end)) begin
      vout_r <= vout_r + 16'h0001;
      vpos_r <= vpos_r + {4'h0, lnk.pitch_y};
      rx_r <= '0;
    end else if (r_go) begin
      rx_r <= rx_r + 16'h0001;
    end else if (r_adv) begin
      vy_r <= vy_r + 16'h0001;
      bank_r <= !bank_r;
    end
  end

  // Linestores: the newest horizontal line overwrites the older bank.
  always_ff @(posedge clk) begin
    if (h_go) begin
      lb_r[bank_r][hout_r[LW-1:0]] <= hpix;
    end
  end

  // Output register: loads only when empty or being taken, so a stalled
  // pixel and its markers stay put.
  always_ff @(posedge clk or posedge core_rst) begin
    if (core_rst) begin
      ov_r <= 1'b0;
      od_r <= '0;
    end else if (o_load) begin
      ov_r <= 1'b1;
      od_r.pix <= vpix;
      od_r.ls <= (x_sel == '0);
      od_r.fs <= (x_sel == '0) && (vout_r == '0);
    end else if (lnk.out_rdy) begin
      ov_r <= 1'b0;
    end
  end

  assign lnk.out_val = ov_r;
  assign lnk.out_pix = od_r.pix;
  assign lnk.out_ls = od_r.ls;
  assign lnk.out_fs = od_r.fs;
endmodule // pvs_scaler
`default_nettype wire

/* File: sim/polyphase_video_scaler_tb_top.sv */
// Bench: pvs_ctrl and pvs_scaler joined by pvs_if; frames go in, scaled frames are checked.
// Assumes the design files and pvs_consts.svh are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "pvs_consts.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module polyphase_video_scaler_tb_top;
  import pvs_pkg::*;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  pvs_pix_t src_pix = 24'h000000;
  logic src_fs = 1'h0;
  logic src_ls = 1'h0;
  logic src_val = 1'h0;
  logic snk_rdy = 1'h1;
  logic par_load = 1'h0;
  logic stall = 1'h0;
  logic [23:0] ppx = 24'h001000;
  logic [23:0] ppy = 24'h001000;
  logic [15:0] iw = 16'h0010;
  logic [15:0] ih = 16'h0010;
  logic [15:0] ow = 16'h0010;
  logic [15:0] oh = 16'h0010;
  logic src_rdy, snk_fs, snk_ls, snk_val, par_busy;
  pvs_pix_t snk_pix;
  int errors = 0;
  int checks_done = 0;
  int rst_seen = 0;
  int rdy_low = 0;
  pvs_word_t got_q[$];
  pvs_if lnk ();
  pvs_scaler u_pvs_scaler (.clk(clk), .sys_rst(sys_rst), .lnk(lnk));
  pvs_ctrl u_pvs_ctrl (.clk(clk), .sys_rst(sys_rst), .lnk(lnk), .src_pix(src_pix),
    .src_fs(src_fs), .src_ls(src_ls), .src_val(src_val), .src_rdy(src_rdy),
    .snk_pix(snk_pix), .snk_fs(snk_fs), .snk_ls(snk_ls), .snk_val(snk_val),
    .snk_rdy(snk_rdy), .par_pitch_x(ppx), .par_pitch_y(ppy), .par_in_ppl(iw),
    .par_in_lpf(ih), .par_out_ppl(ow), .par_out_lpf(oh), .par_load(par_load),
    .par_busy(par_busy));
  pvs_scaler_properties u_pvs_scaler_properties (.clk(clk), .sys_rst(sys_rst),
    .scale_rst(lnk.scale_rst), .in_pix(lnk.in_pix), .in_fs(lnk.in_fs), .in_ls(lnk.in_ls),
    .in_val(lnk.in_val), .in_rdy(lnk.in_rdy), .out_pix(lnk.out_pix), .out_fs(lnk.out_fs),
    .out_ls(lnk.out_ls), .out_val(lnk.out_val), .out_rdy(lnk.out_rdy),
    .out_ppl(lnk.out_ppl), .out_lpf(lnk.out_lpf));
  always #4 clk = ~clk;
  // Captures the sink pulses and counts scaler resets and input stalls.
  always @(posedge clk) begin
    if (snk_val) got_q.push_back({snk_fs, snk_ls, snk_pix});
    if (lnk.scale_rst) rst_seen++;
    if (!lnk.in_rdy && !sys_rst && !lnk.scale_rst) rdy_low++;
  end
  // The sink toggles its ready in stall mode so the output hold is exercised.
  always @(posedge clk) begin
    #1;
    snk_rdy = stall ? ~snk_rdy : 1'h1;
  end
  // Source pattern: each channel a different function of column and row.
  function automatic logic [7:0] sp(int c, int x, int y);
    int v;
    v = (c == 0) ? x * 9 + y * 4 : (c == 1) ? y * 15 + x : x * y;
    return v[7:0];
  endfunction
  function automatic logic [7:0] mix(logic [7:0] a, logic [7:0] b, int ph);
    int v;
    v = a * (256 - 16 * ph) + b * 16 * ph;
    return v[15:8];
  endfunction
  // Horizontal blend of two rows first, then the vertical blend of the results.
  function automatic pvs_pix_t exp_pix(int x, int y);
    int px, py, x0, x1, y0, y1;
    pvs_pix_t r;
    px = x * ppx;
    py = y * ppy;
    x0 = (px >> 12) < iw ? px >> 12 : iw - 1;
    y0 = (py >> 12) < ih ? py >> 12 : ih - 1;
    x1 = x0 + 1 < iw ? x0 + 1 : x0;
    y1 = y0 + 1 < ih ? y0 + 1 : y0;
    for (int c = 0; c < 3; c++) begin
      r[c*8 +: 8] = mix(mix(sp(c, x0, y0), sp(c, x1, y0), px[11:8]),
        mix(sp(c, x0, y1), sp(c, x1, y1), px[11:8]), py[11:8]);
    end
    return r;
  endfunction
  // Holds one pixel until the source side is ready; leaves valid up for back to back.
  task put(logic fs, logic ls, pvs_pix_t p);
    int n;
    src_fs = fs;
    src_ls = ls;
    src_pix = p;
    src_val = 1'h1;
    n = 0;
    while (!src_rdy && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
  endtask
  // An idle cycle with junk and both markers up, all to be ignored.
  task gap;
    src_val = 1'h0;
    src_fs = 1'h1;
    src_ls = 1'h1;
    src_pix = 24'hA5A5A5;
    @(posedge clk);
    #1;
  endtask
  task frame;
    for (int y = 0; y < ih; y++) begin
      for (int x = 0; x < iw; x++) begin
        put(x == 0 && y == 0, x == 0, {sp(2, x, y), sp(1, x, y), sp(0, x, y)});
        if ((x + y) % 5 == 4) gap();
      end
    end
    gap();
  endtask
  task setp(logic [23:0] px, logic [23:0] py, logic [15:0] w, logic [15:0] h,
      logic [15:0] w2, logic [15:0] h2);
    int r0;
    {ppx, ppy, iw, ih, ow, oh} = {px, py, w, h, w2, h2};
    r0 = rst_seen;
    par_load = 1'h1;
    @(posedge clk);
    #1;
    par_load = 1'h0;
    for (int n = 0; n < 200 && par_busy !== 1'h0; n++) @(posedge clk);
    repeat (3) @(posedge clk);
    #1;
    `CHK("scale_rst pulses", r0 + 1, rst_seen)
    `CHK("pitch_x", px, lnk.pitch_x)
    `CHK("pitch_y", py, lnk.pitch_y)
    got_q.delete();
  endtask
  // Waits for a whole output frame, then compares every pixel and marker.
  task check;
    for (int n = 0; n < 20000 && got_q.size() < ow * oh; n++) @(posedge clk);
    repeat (20) @(posedge clk);
    #1;
    `CHK("output count", ow * oh, got_q.size())
    for (int i = 0; i < got_q.size() && i < ow * oh; i++) begin
      `CHK("pixel", exp_pix(i % ow, i / ow), got_q[i].pix)
      `CHK("line start", i % ow == 0, got_q[i].ls)
      `CHK("frame start", i == 0, got_q[i].fs)
    end
  endtask
  task end_of_test;
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Four frames of at most 1024 outputs need well under 20000 cycles.
  initial begin
    #400000;
    errors++;
    end_of_test();
  end
  initial begin
    int r;
    repeat (3) @(posedge clk);
    #1;
    sys_rst = 1'h0;
    repeat (2) @(posedge clk);
    #1;
    put(1'h0, 1'h1, 24'h123456);
    put(1'h0, 1'h0, 24'h654321);
    gap();
    frame();
    check();
    stall = 1'h1;
    setp(24'h002000, 24'h002000, 16'h0010, 16'h0010, 16'h0008, 16'h0008);
    r = rdy_low;
    frame();
    check();
    `CHK("input kept ready", r, rdy_low)
    stall = 1'h0;
    setp(24'h000800, 24'h000800, 16'h0010, 16'h0010, 16'h0020, 16'h0020);
    r = rdy_low;
    frame();
    check();
    `CHK("input throttled", 1'h1, rdy_low > r)
    setp(24'h000C00, 24'h000C00, 16'h0010, 16'h0010, 16'h0014, 16'h0014);
    for (int i = 0; i < 12; i++) put(i == 0, i == 0, 24'h0F0F0F);
    gap();
    setp(24'h000C00, 24'h000C00, 16'h0010, 16'h0010, 16'h0014, 16'h0014);
    put(1'h0, 1'h1, 24'h0F0F0F);
    gap();
    frame();
    check();
    end_of_test();
  end
endmodule // polyphase_video_scaler_tb_top
`default_nettype wire

/* File: sim/pvs_scaler_properties.sv */
// Checker for the scaler link: handshakes, markers and output framing.
// Assumes the bench ties every input except clk and sys_rst to the pvs_if signal of the same name.
`timescale 1ns/1ps
`default_nettype none
`include "pvs_consts.svh"
module pvs_scaler_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scale_rst,
  input wire logic [`PVS_PIX_W-1:0] in_pix,
  input wire logic in_fs,
  input wire logic in_ls,
  input wire logic in_val,
  input wire logic in_rdy,
  input wire logic [`PVS_PIX_W-1:0] out_pix,
  input wire logic out_fs,
  input wire logic out_ls,
  input wire logic out_val,
  input wire logic out_rdy,
  input wire logic [`PVS_DIM_W-1:0] out_ppl,
  input wire logic [`PVS_DIM_W-1:0] out_lpf
);
  logic seen_r;
  logic [`PVS_DIM_W-1:0] xc_r;
  logic [`PVS_DIM_W-1:0] yc_r;
  // A frame marker restarts the position, so one slip is reported only up to the next frame start, not forever.
  wire logic out_acc = out_val && out_rdy;
  wire logic [`PVS_DIM_W-1:0] xb = out_fs ? 16'h0000 : xc_r;
  wire logic [`PVS_DIM_W-1:0] yb = out_fs ? 16'h0000 : yc_r;
  wire logic x_end = (xb == out_ppl - 16'h0001);
  wire logic y_end = (yb == out_lpf - 16'h0001);
  wire logic [`PVS_DIM_W-1:0] xc_nxt = x_end ? 16'h0000 : xb + 16'h0001;
  wire logic [`PVS_DIM_W-1:0] yc_nxt = !x_end ? yb : (y_end ? 16'h0000 : yb + 16'h0001);
  // Tracks the first accepted frame start and the output pixel position.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      seen_r <= 1'h0;
      xc_r <= 16'h0000;
      yc_r <= 16'h0000;
    end else if (scale_rst) begin
      seen_r <= 1'h0;
      xc_r <= 16'h0000;
      yc_r <= 16'h0000;
    end else begin
      if (in_val && in_rdy && in_fs) seen_r <= 1'h1;
      if (out_acc) xc_r <= xc_nxt;
      if (out_acc) yc_r <= yc_nxt;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst || scale_rst);
  a_out_hold_stall: assert property (out_val && !out_rdy |=>
    out_val && $stable(out_pix) && $stable({out_fs, out_ls})) else $error("output moved in stall");
  a_in_hold_stall: assert property (in_val && !in_rdy |=>
    in_val && $stable(in_pix) && $stable({in_fs, in_ls})) else $error("input moved in stall");
  a_out_fs_ls: assert property (out_val && out_fs |-> out_ls)
    else $error("output frame start without line start");
  a_in_fs_ls: assert property (in_val && in_fs |-> in_ls)
    else $error("input frame start without line start");
  a_rst_quiet: assert property (disable iff (sys_rst) scale_rst |-> !out_val ##1 !out_val)
    else $error("output valid right after scaler reset");
  a_no_early_out: assert property (out_val |-> seen_r)
    else $error("output before any frame start");
  a_line_start_pos: assert property (out_acc && !out_fs |-> out_ls == (xc_r == 16'h0000))
    else $error("line start not at first column");
  a_frame_start_pos: assert property (out_acc && out_fs |-> xc_r == 16'h0000 && yc_r == 16'h0000)
    else $error("frame start not at first pixel");
  a_params_hold: assert property (disable iff (sys_rst) !scale_rst |-> $stable({out_ppl, out_lpf}))
    else $error("scale inputs changed without a scaler reset");
  a_rst_idle: assert property (disable iff (sys_rst) scale_rst |-> !in_val)
    else $error("scaler reset while a pixel was offered");
endmodule // pvs_scaler_properties
`default_nettype wire
